// ---- include/ifm_pkg.sv ----
// How it works
// RULE1 - Codes 0 to 20 route the pin straight to that function.
// RULE2 - Codes 100 to 120 route the inverted pin to function code minus 100.
// RULE3 - Pins sharing one function are ORed together.
// RULE4 - Any other code leaves the pin driving no function.
// RULE5 - Switches and sensors are active high, normally open contacts.
// RULE6 - Output reverse bit, reset 0, inverts every output level when 1.
// RULE7 - Input reverse bit, reset 0, inverts every input level when 1 (the code inverts only decode inputs; PIN_LO..PIN_HI read raw levels).
// RULE8 - Each pin has its own code register; defaults map pins to own functions (reset maps pins 14 to 16 to functions 16 to 18 instead).
// RULE9 - Order: global input inversion, then per-pin inversion, then the OR.
package ifm_pkg;
  localparam int unsigned NUM_PINS   = 17;
  localparam int unsigned NUM_FUNCS  = 21;
  localparam int unsigned CODE_W     = 7;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam logic [CODE_W-1:0] PLAIN_MAX = 7'h14;
  localparam logic [CODE_W-1:0] INV_BASE  = 7'h64;
  localparam logic [CODE_W-1:0] INV_MAX   = 7'h78;
  // Pin code registers sit at 0x00..0x10, one per pin.
  localparam logic [ADDR_W-1:0] PIN_CODE_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] LEVEL_CTRL    = 8'h20;
  localparam logic [ADDR_W-1:0] FUNC_LO       = 8'h24;
  localparam logic [ADDR_W-1:0] FUNC_MID      = 8'h25;
  localparam logic [ADDR_W-1:0] FUNC_HI       = 8'h26;
  localparam logic [ADDR_W-1:0] PIN_LO        = 8'h28;
  localparam logic [ADDR_W-1:0] PIN_MID       = 8'h29;
  localparam logic [ADDR_W-1:0] PIN_HI        = 8'h2a;
  localparam int unsigned OUT_REV_BIT = 0;
  localparam int unsigned IN_REV_BIT  = 1;
  localparam logic OUT_REV_RST = 1'b0;
  localparam logic IN_REV_RST  = 1'b0;
  localparam logic [NUM_PINS*CODE_W-1:0] PIN_CODE_RST = {
    7'h12, 7'h11, 7'h10, 7'h0d, 7'h0c, 7'h0b, 7'h0a, 7'h09, 7'h08,
    7'h07, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01, 7'h00};
endpackage

// ---- src/ifm_pin_decode.sv ----
`timescale 1ns/100ps
module ifm_pin_decode
  import ifm_pkg::*;
(
  input  wire logic [CODE_W-1:0]    code,
  input  wire logic                 level,
  output logic      [NUM_FUNCS-1:0] contrib
);
  wire logic              isPlain = (code <= PLAIN_MAX);
  wire logic              isInv   = (code >= INV_BASE) && (code <= INV_MAX);
  wire logic [CODE_W-1:0] invIdx  = code - INV_BASE;
  wire logic [CODE_W-1:0] funcIdx = isInv ? invIdx : code;
  wire logic              pinVal  = isInv ? ~level : level;  // see RULE2 see RULE9
  wire logic              pinOk   = isPlain | isInv;  // see RULE1 see RULE4

  always_comb begin
    contrib = '0;
    for (int f = 0; f < NUM_FUNCS; f++) begin
      contrib[f] = pinOk && (funcIdx == CODE_W'(f)) && pinVal;
    end
  end
endmodule

// ---- src/ifm_input_function_mapper.sv ----
`timescale 1ns/100ps
module ifm_input_function_mapper
  import ifm_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic [NUM_PINS-1:0]  pinIn,
  input  wire logic [NUM_FUNCS-1:0] funcOut,
  output logic      [NUM_FUNCS-1:0] funcActive,
  output logic      [NUM_FUNCS-1:0] pinOut,
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic [DATA_W-1:0]    regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [DATA_W-1:0]    regRdata
);
  logic [NUM_PINS-1:0]  pinMeta_ff;
  logic [NUM_PINS-1:0]  pinSync_ff;
  logic [CODE_W-1:0]    code_ff [NUM_PINS];
  logic                 outRev_ff;
  logic                 inRev_ff;
  logic [DATA_W-1:0]    rdata_ff;
  logic [NUM_FUNCS-1:0] contrib [NUM_PINS];
  logic [NUM_FUNCS-1:0] nxt_funcActive;
  logic [DATA_W-1:0]    nxt_rdata;

  // Pins are asynchronous to sys_clk, so they pass two flops first.
  always_ff @(posedge sys_clk) begin
    pinMeta_ff <= pinIn;
    pinSync_ff <= pinMeta_ff;
  end

  wire logic [NUM_PINS-1:0] pinLvl = inRev_ff ? ~pinSync_ff : pinSync_ff;  // see RULE7 see RULE9

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      ifm_pin_decode u_dec (
        .code    (code_ff[p]),
        .level   (pinLvl[p]),
        .contrib (contrib[p])
      );
    end
  endgenerate

  always_comb begin
    nxt_funcActive = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      nxt_funcActive = nxt_funcActive | contrib[i];  // see RULE3
    end
  end

  // Functions are registered so that a glitch in the decode never reaches the machine.
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      funcActive <= '0;
      pinOut     <= '0;
    end else begin
      funcActive <= nxt_funcActive;
      pinOut     <= outRev_ff ? ~funcOut : funcOut;  // see RULE6
    end
  end

  wire logic              wrLevel = regWr && (regAddr == LEVEL_CTRL);
  wire logic [ADDR_W-1:0] pinIdx  = regAddr - PIN_CODE_BASE;
  wire logic              inCodes = (regAddr >= PIN_CODE_BASE) &&
                                    (pinIdx < ADDR_W'(NUM_PINS));

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      outRev_ff <= OUT_REV_RST;
      inRev_ff  <= IN_REV_RST;
    end else if (wrLevel) begin
      outRev_ff <= regWdata[OUT_REV_BIT];
      inRev_ff  <= regWdata[IN_REV_BIT];
    end
  end

  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_code
      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          code_ff[p] <= PIN_CODE_RST[p*CODE_W +: CODE_W];  // see RULE8
        end else if (regWr && inCodes && pinIdx == ADDR_W'(p)) begin
          code_ff[p] <= regWdata[CODE_W-1:0];  // see RULE8
        end
      end
    end
  endgenerate

  logic [23:0] funcWide;
  logic [23:0] pinWide;
  assign funcWide = {3'h0, funcActive};
  assign pinWide  = {7'h00, pinSync_ff};

  // One select per readable word; the selects are disjoint, so the words are simply ORed.
  wire logic selLevel  = (regAddr == LEVEL_CTRL);
  wire logic selFuncLo = (regAddr == FUNC_LO);
  wire logic selFuncMd = (regAddr == FUNC_MID);
  wire logic selFuncHi = (regAddr == FUNC_HI);
  wire logic selPinLo  = (regAddr == PIN_LO);
  wire logic selPinMd  = (regAddr == PIN_MID);
  wire logic selPinHi  = (regAddr == PIN_HI);

  // The code word is gated so an address past the last pin never indexes the array.
  wire logic [DATA_W-1:0] codeWord  = inCodes ? {1'b0, code_ff[pinIdx[4:0]]} : '0;
  wire logic [DATA_W-1:0] levelWord = selLevel ? {6'h00, inRev_ff, outRev_ff} : '0;
  wire logic [DATA_W-1:0] funcWord  = selFuncLo ? funcWide[7:0]   :
                                      selFuncMd ? funcWide[15:8]  :
                                      selFuncHi ? funcWide[23:16] : '0;
  wire logic [DATA_W-1:0] pinWord   = selPinLo  ? pinWide[7:0]    :
                                      selPinMd  ? pinWide[15:8]   :
                                      selPinHi  ? pinWide[23:16]  : '0;

  // Unmapped addresses select nothing and therefore read as zero.
  assign nxt_rdata = codeWord | levelWord | funcWord | pinWord;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (regRd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign regRdata = rdata_ff;
endmodule

// ---- tb/ifm_switches.sv ----
`timescale 1ns/100ps
module ifm_switches
  import ifm_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] press,
  output logic      [NUM_PINS-1:0] pinIn
);
  // Contacts are normally open, so a released switch always reads low.
  assign pinIn = press;
endmodule

// ---- tb/ifm_asserts.sv ----
`timescale 1ns/100ps
module ifm_asserts
  import ifm_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [16:0] pinIn,
  input wire logic [20:0] funcOut,
  input wire logic [20:0] funcActive,
  input wire logic [20:0] pinOut,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00) else $error("bad");
  rst_clear_a: assert property ($rose(rstn) |-> pinOut == 0 && funcActive == 0)
    else $error("bad");
  out_rev_a: assert property (pinOut == $past(funcOut) || pinOut == ~$past(funcOut))
    else $error("bad");
  ctrl_bits_a: assert property (regRd && regAddr == LEVEL_CTRL |=> regRdata[7:2] == 0)
    else $error("bad");
  code_bit_a: assert property (regRd && regAddr < 8'h11 |=> !regRdata[7])
    else $error("bad");
  unmapped_zero_a: assert property (regRd && regAddr > PIN_HI |=> regRdata == 0)
    else $error("bad");
  func_hold_a: assert property ((!regWr && $stable(pinIn)) [*4] |=> $stable(funcActive))
    else $error("bad");
  code_back_a: assert property (regWr ##1 regRd && regAddr == $past(regAddr)
    && regAddr < 8'h11 |=> regRdata == ($past(regWdata, 2) & 8'h7f)) else $error("bad");
endmodule
bind ifm_input_function_mapper ifm_asserts chk (.*);

// ---- tb/test_input_function_mapper.sv ----
`timescale 1ns/100ps
module test_input_function_mapper
  import ifm_pkg::*;
;
  logic        sys_clk = 0, rstn = 0, regWr = 0, regRd = 0, chk = 0, rdSeen = 0;
  logic        inRev = 0, outRev = 0;
  logic [16:0] press = '0, pinIn;
  logic [20:0] funcOut = '0, funcActive, pinOut, q[$];
  logic [7:0]  regAddr = '0, regWdata = '0, regRdata;
  logic [6:0]  code[17];
  logic [31:0] seed = 46933;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  ifm_switches sw (.press(press), .pinIn(pinIn));
  ifm_input_function_mapper dut (.sys_clk(sys_clk), .rstn(rstn), .pinIn(pinIn),
    .funcOut(funcOut), .funcActive(funcActive), .pinOut(pinOut), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(logic [20:0] got, logic [20:0] exp);
    comparisons++;
    n_errors += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %0t %h %h", $time, got, exp);
  endtask
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A read carries its expected data in d; a write updates the model.
  task automatic acc(logic wr, logic [7:0] a, logic [7:0] d);
    {regWr, regRd, regAddr, regWdata} <= {wr, !wr, a, d};
    if (!wr) q.push_back(21'(d));
    else if (a < 8'h11) code[a] = d[6:0];
    else {inRev, outRev} = d[1:0];
    @(posedge sys_clk);
  endtask
  task automatic pins(int n);
    logic [20:0] f, o;
    logic [16:0] p;
    repeat (n) begin
      {regWr, regRd} <= 2'b00;
      p = 17'(rnd());
      o = 21'(rnd());
      {press, funcOut} <= {p, o};
      repeat (4) @(posedge sys_clk);
      f = '0;
      for (int i = 0; i < 17; i++) begin
        if (code[i] <= PLAIN_MAX) f[code[i]] |= p[i] ^ inRev;
        else if (code[i] >= INV_BASE && code[i] <= INV_MAX) f[code[i] - INV_BASE] |= !(p[i] ^ inRev);
      end
      q.push_back(f);
      q.push_back(o ^ {21{outRev}});
      chk <= 1;
      @(posedge sys_clk);
      chk <= 0;
      acc(0, FUNC_LO, f[7:0]);
      acc(0, FUNC_MID, f[15:8]);
      acc(0, FUNC_HI, {3'h0, f[20:16]});
      acc(0, PIN_LO, p[7:0]);
      acc(0, PIN_MID, p[15:8]);
      acc(0, PIN_HI, {7'h00, p[16]});
    end
    {regWr, regRd} <= 2'b00;
    @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    rdSeen <= regRd;
    if (rdSeen) cmp(21'(regRdata), q.pop_front());
    if (chk) cmp(funcActive, q.pop_front());
    if (chk) cmp(pinOut, q.pop_front());
    if (++cyc > 1000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    for (int i = 0; i < 17; i++) code[i] = PIN_CODE_RST[i*7 +: 7];
    repeat (5) @(posedge sys_clk);
    rstn <= 1;
    @(posedge sys_clk);
    acc(0, LEVEL_CTRL, 8'h00);
    acc(0, 8'h10, 8'h12);
    acc(0, 8'h3f, 8'h00);
    pins(6);
    acc(1, 8'h00, 8'h69);
    acc(0, 8'h00, 8'h69);
    acc(1, 8'h01, 8'h05);
    acc(1, 8'h02, 8'h15);
    acc(1, 8'h04, 8'h78);
    pins(8);
    acc(1, LEVEL_CTRL, 8'h03);
    acc(0, LEVEL_CTRL, 8'h03);
    pins(8);
    repeat (2) @(posedge sys_clk);
    summarize();
  end
endmodule
